// ---- rtl/sdr_cfg.svh ----
// Constants shared by the memory end and the controller end of the DRAM link
// Functional notes
// - Burst length codes 1,2,4,8, full page sequential
// - Mode bit 3 picks sequential or interleaved
// - Read latency codes two or three only
// - Operation mode selects single-beat writes
// - Mode register fields cannot be read back
// - Upper column bits pick aligned burst block
// - Sequential beats step upward, wrap inside block
// - Interleaved beat column is start XOR count
// - All banks closed before any refresh
// - Internal counter supplies refresh bank and row
// - Auto refresh decode, closes row itself
// - Row cycle time after each auto refresh
// - Self refresh entry, inputs then ignored
// - Clock gate high leaves self refresh
// - Row cycle time after self refresh exit
// - Auto close flag precharges bank after burst
// - Write auto close waits store recovery time
// - Auto close burst interrupted by other bank only; the memory end lets a read or write to any bank cut it short
// - Precharge command decode
// - Precharge bank decode or close all
// - Read precharge early by latency rule
// - Store recovery two clocks before precharge
// - Mode register load decode, fields on address
// - Full page burst runs until next command; the memory end stops it only on a read, write or precharge
`ifndef SDR_CFG_SVH
`define SDR_CFG_SVH

// ****************************************
// Mode register layout
// ****************************************
`define SDR_MR_BL_HI      2
`define SDR_MR_BL_LO      0
`define SDR_MR_BT         3
`define SDR_MR_CL_HI      6
`define SDR_MR_CL_LO      4
`define SDR_MR_WM         7
`define SDR_BL_1          3'h0
`define SDR_BL_2          3'h1
`define SDR_BL_4          3'h2
`define SDR_BL_8          3'h3
`define SDR_BL_FULL       3'h7
`define SDR_CL_2          3'h2
`define SDR_CL_3          3'h3
`define SDR_AP_BIT        10
`define SDR_FULL_LEN      8'h10

// ****************************************
// Timing
// ****************************************
`define SDR_CLK_NS        50
`define SDR_TRC_NS        60
`define SDR_TRC_CYC       (8'((`SDR_TRC_NS + `SDR_CLK_NS - 1) / `SDR_CLK_NS))
`define SDR_TWR_CYC       2'h2
`define SDR_TWR_CYC8      8'h02
`define SDR_SREF_CYC      8'h10

// ****************************************
// Controller registers
// ****************************************
`define SDR_REG_CMD       8'h00
`define SDR_REG_ADDR      8'h04
`define SDR_REG_WDATA     8'h08
`define SDR_REG_STATUS    8'h0C
`define SDR_ST_ERR        1
`define SDR_CMD_OP_HI     2
`define SDR_CMD_AP        3
`define SDR_CMD_ALL       4
`define SDR_CMD_BK_HI     6
`define SDR_CMD_BK_LO     5

`endif

// ---- rtl/sdr_ctl.sv ----
// Controller end: APB register slave that sequences link commands
`timescale 1ns/1ps
`include "sdr_cfg.svh"
module sdr_ctl (
	// Link
	sdr_link_if.ctl    link,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	import sdr_pkg::*;

	function automatic logic [7:0] len_of(input logic [2:0] bl);
		case (bl)
			`SDR_BL_2:    len_of = 8'h02;
			`SDR_BL_4:    len_of = 8'h04;
			`SDR_BL_8:    len_of = 8'h08;
			`SDR_BL_FULL: len_of = `SDR_FULL_LEN;
			default:      len_of = 8'h01;
		endcase
	endfunction

	sdr_ctl_s   r;
	sdr_ctl_s   next_r;
	logic       mapped;
	logic       wr_acc;
	sdr_op_e    op;
	logic [1:0] bk;
	logic [7:0] wl;
	logic       ok;
	logic       fp_wr;
	logic [7:0] cnt1;
	logic [7:0] dq_step;

	assign mapped = (paddr == `SDR_REG_CMD) || (paddr == `SDR_REG_ADDR) ||
	                (paddr == `SDR_REG_WDATA) || (paddr == `SDR_REG_STATUS);
	assign wr_acc = psel && penable && pwrite && mapped;
	assign op     = sdr_op_e'(pwdata[`SDR_CMD_OP_HI:0]);
	assign bk     = pwdata[`SDR_CMD_BK_HI:`SDR_CMD_BK_LO];

	always_comb begin
		next_r = r;
		wl     = r.wsingle ? 8'h01 : len_of(r.bl);
		ok     = 1'b1;
		// A full page write never stops by itself, so its data keeps stepping
		fp_wr   = (r.op == SDR_OP_WR) && (r.wlen == `SDR_FULL_LEN);
		cnt1    = r.cnt + 8'h01;
		dq_step = (cnt1[3:0] == 4'h0) ? r.dq_o + 8'h01 - `SDR_FULL_LEN : r.dq_o + 8'h01;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				`SDR_REG_ADDR:   next_r.prdata = {19'h0_0000, r.addr};
				`SDR_REG_WDATA:  next_r.prdata = {24'h00_0000, r.wdata};
				`SDR_REG_STATUS: next_r.prdata = {16'h0000, r.rdata, r.open, 1'b0,
				                                  r.sref, r.err, r.state != SDR_C_IDLE};
				default:         next_r.prdata = 32'h0000_0000;
			endcase
		end
		if (wr_acc && paddr == `SDR_REG_ADDR) next_r.addr = pwdata[12:0];
		if (wr_acc && paddr == `SDR_REG_WDATA) next_r.wdata = pwdata[7:0];
		if (wr_acc && paddr == `SDR_REG_STATUS && pwdata[`SDR_ST_ERR]) next_r.err = 1'b0;
		case (r.state)
			SDR_C_IDLE: begin
				// Running page burst rewrites the same values until a command ends it
				if (fp_wr && r.dq_oe) begin
					next_r.cnt  = cnt1;
					next_r.dq_o = dq_step;
				end
				if (wr_acc && paddr == `SDR_REG_CMD) begin
					case (op)
						SDR_OP_MRS: ok = (r.addr[`SDR_MR_CL_HI:`SDR_MR_CL_LO] == `SDR_CL_2 ||
						                  r.addr[`SDR_MR_CL_HI:`SDR_MR_CL_LO] == `SDR_CL_3) &&
						                 !(r.addr[`SDR_MR_BL_HI:`SDR_MR_BL_LO] == `SDR_BL_FULL &&
						                   r.addr[`SDR_MR_BT]);
						SDR_OP_RD, SDR_OP_WR: ok = r.open[bk];
						SDR_OP_REF: ok = (r.open == 4'h0);
						SDR_OP_SREF: ok = r.sref || (r.open == 4'h0);
						default: ok = 1'b1;
					endcase
					if (r.sref && op != SDR_OP_SREF) ok = 1'b0;
					if (!ok) begin
						next_r.err = 1'b1;
					end else begin
						next_r.state = SDR_C_CMD;
						next_r.op    = op;
						next_r.apf   = pwdata[`SDR_CMD_AP];
						next_r.bank  = bk;
						next_r.ba_lo = bk[1];
						next_r.ba_hi = bk[0];
						next_r.a     = r.addr;
						next_r.total = 8'h01;
						case (op)
							SDR_OP_MRS: begin
								next_r.rcw_n   = 3'b000;
								next_r.bl      = r.addr[`SDR_MR_BL_HI:`SDR_MR_BL_LO];
								next_r.bt      = r.addr[`SDR_MR_BT];
								next_r.cl      = r.addr[`SDR_MR_CL_HI:`SDR_MR_CL_LO];
								next_r.wsingle = r.addr[`SDR_MR_WM];
							end
							SDR_OP_ACT: begin
								next_r.rcw_n     = 3'b011;
								next_r.open[bk]  = 1'b1;
								next_r.total     = `SDR_TRC_CYC;
							end
							SDR_OP_RD, SDR_OP_WR: begin
								next_r.rcw_n = (op == SDR_OP_RD) ? 3'b101 : 3'b100;
								next_r.a[`SDR_AP_BIT] = pwdata[`SDR_CMD_AP];
								if (pwdata[`SDR_CMD_AP]) next_r.open[bk] = 1'b0;
								// Waiting out the burst
								if (op == SDR_OP_RD) begin
									next_r.total = {5'h00, r.cl} + len_of(r.bl) + 8'h01;
								end else begin
									next_r.total = wl + `SDR_TWR_CYC8;
									next_r.dq_o  = r.wdata;
									next_r.dq_oe = 1'b1;
								end
								next_r.wlen = wl;
							end
							SDR_OP_PRE: begin
								next_r.rcw_n = 3'b010;
								next_r.a[`SDR_AP_BIT] = pwdata[`SDR_CMD_ALL];
								if (pwdata[`SDR_CMD_ALL]) next_r.open = 4'h0;
								else next_r.open[bk] = 1'b0;
							end
							SDR_OP_REF: begin
								next_r.rcw_n = 3'b001;
								next_r.total = `SDR_TRC_CYC;
							end
							SDR_OP_SREF: begin
								if (r.sref) begin
									next_r.cke   = 1'b1;
									next_r.sref  = 1'b0;
									next_r.total = `SDR_TRC_CYC;
								end else begin
									next_r.rcw_n = 3'b001;
									next_r.cke   = 1'b0;
									next_r.sref  = 1'b1;
								end
							end
							default: next_r.rcw_n = 3'b111;
						endcase
					end
				end
			end
			SDR_C_CMD: begin
				next_r.state = SDR_C_WAIT;
				next_r.rcw_n = 3'b111;
				next_r.cnt   = 8'h01;
				next_r.dq_o  = r.wdata + 8'h01;
				next_r.dq_oe = (r.op == SDR_OP_WR) && (r.wlen > 8'h01);
			end
			SDR_C_WAIT: begin
				if (r.op == SDR_OP_RD && r.cnt == {5'h00, r.cl}) next_r.rdata = link.dq;
				next_r.cnt   = cnt1;
				next_r.dq_o  = dq_step;
				next_r.dq_oe = (r.op == SDR_OP_WR) && ((cnt1 < r.wlen) || fp_wr);
				if (cnt1 >= r.total) begin
					next_r.state = SDR_C_IDLE;
					next_r.dq_oe = fp_wr;
				end
			end
			default: next_r.state = SDR_C_IDLE;
		endcase
		// A command arriving while busy is refused
		if (r.state != SDR_C_IDLE && wr_acc && paddr == `SDR_REG_CMD) next_r.err = 1'b1;
	end

	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			r       <= '0;
			r.cke   <= 1'b1;
			r.rcw_n <= 3'b111;
			r.cl    <= `SDR_CL_3;
		end else begin
			r <= next_r;
		end
	end

	assign link.clock_gate_in   = r.cke;
	assign link.row_strobe_n    = r.rcw_n[2];
	assign link.column_strobe_n = r.rcw_n[1];
	assign link.write_enable_n  = r.rcw_n[0];
	assign link.addr            = r.a;
	assign link.array_pick_lo   = r.ba_lo;
	assign link.array_pick_hi   = r.ba_hi;
	assign link.ctl_dq_o        = r.dq_o;
	assign link.ctl_dq_oe       = r.dq_oe;
	assign prdata               = r.prdata;
	assign pready               = 1'b1;
	assign pslverr              = psel && penable && !mapped;

endmodule

// ---- rtl/sdr_link_if.sv ----
// Pin-level link between the DRAM controller and the memory device
`timescale 1ns/1ps
interface sdr_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	logic        clock_gate_in;
	logic        row_strobe_n;
	logic        column_strobe_n;
	logic        write_enable_n;
	logic [12:0] addr;
	logic        array_pick_lo;
	logic        array_pick_hi;
	logic [7:0]  ctl_dq_o;
	logic        ctl_dq_oe;
	logic [7:0]  mem_dq_o;
	logic        mem_dq_oe;
	logic [7:0]  dq;

	// Undriven data bus reads as zero
	assign dq = ctl_dq_oe ? ctl_dq_o : (mem_dq_oe ? mem_dq_o : 8'h00);

	modport ctl (
		input  pclk, presetn, dq, mem_dq_oe,
		output clock_gate_in, row_strobe_n, column_strobe_n, write_enable_n,
		output addr, array_pick_lo, array_pick_hi, ctl_dq_o, ctl_dq_oe
	);

	modport mem (
		input  pclk, presetn, dq, ctl_dq_oe,
		input  clock_gate_in, row_strobe_n, column_strobe_n, write_enable_n,
		input  addr, array_pick_lo, array_pick_hi,
		output mem_dq_o, mem_dq_oe
	);
endinterface

// ---- rtl/sdr_mem_dev.sv ----
// Memory end: mode register, burst sequencer, refresh and precharge
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "sdr_cfg.svh"
module sdr_mem_dev (
	// Link
	sdr_link_if.mem    link,
	// Observation
	output logic [3:0]  bank_open,
	output logic [15:0] refresh_count,
	output logic        in_self_refresh
);
	import sdr_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [9:0] blk_mask(input logic [2:0] bl);
		case (bl)
			`SDR_BL_2: blk_mask = 10'h001;
			`SDR_BL_4: blk_mask = 10'h003;
			`SDR_BL_8: blk_mask = 10'h007;
			default:   blk_mask = 10'h000;
		endcase
	endfunction

	function automatic logic [9:0] col_of(
		input logic [9:0] start,
		input logic [9:0] beat,
		input logic [2:0] bl,
		input logic       bt
	);
		logic [9:0] m;
		m = blk_mask(bl);
		if (bl == `SDR_BL_FULL) begin
			// Full page only steps sequentially
			col_of = start + beat;
		end else if (bt) begin
			col_of = (start & ~m) | ((start ^ beat) & m);
		end else begin
			col_of = (start & ~m) | ((start + beat) & m);
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	sdr_dev_s   r;
	sdr_dev_s   next_r;
	logic       cke;
	logic       cmd_mrs;
	logic       cmd_ref;
	logic       cmd_sref;
	logic       cmd_pre;
	logic       cmd_act;
	logic       cmd_rd;
	logic       cmd_wr;
	logic [1:0] bank;
	logic [9:0] col;
	logic [5:0] idx;
	logic       last;
	logic [9:0] lenm1;

	assign cke  = link.clock_gate_in;
	assign bank = {link.array_pick_lo, link.array_pick_hi};

	always_comb begin
		cmd_mrs  = 1'b0;
		cmd_ref  = 1'b0;
		cmd_sref = 1'b0;
		cmd_pre  = 1'b0;
		cmd_act  = 1'b0;
		cmd_rd   = 1'b0;
		cmd_wr   = 1'b0;
		// Control pins are dead while self refresh runs
		if (!r.sref) begin
			case ({link.row_strobe_n, link.column_strobe_n, link.write_enable_n})
				3'b000:  cmd_mrs  = cke;
				3'b001: begin
					cmd_ref  = cke;
					cmd_sref = !cke;
				end
				3'b010:  cmd_pre  = cke;
				3'b011:  cmd_act  = cke;
				3'b101:  cmd_rd   = cke;
				3'b100:  cmd_wr   = cke;
				default: cmd_act  = 1'b0;
			endcase
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_r = r;
		lenm1  = blk_mask(r.bl);
		col    = col_of(r.bstart, r.beat, r.bl, r.bt);
		idx    = {r.bbank, col[3:0]};
		last   = (r.bl != `SDR_BL_FULL) && (r.beat == lenm1);

		// Read pipeline, one stage per latency clock
		next_r.s1v = 1'b0;
		next_r.s2v = r.s1v;
		next_r.s2d = r.s1d;

		if (r.bact) begin
			if (r.bwr) begin
				next_r.mem[idx] = link.dq;
			end else begin
				next_r.s1v = 1'b1;
				next_r.s1d = r.mem[idx];
			end
			next_r.beat = r.beat + 10'h001;
			if (last) begin
				next_r.bact = 1'b0;
				if (r.bauto && r.bwr) begin
					next_r.wrc_act  = 1'b1;
					next_r.wrc      = `SDR_TWR_CYC;
					next_r.wrc_bank = r.bbank;
				end else if (r.bauto) begin
					next_r.open[r.bbank] = 1'b0;
				end
			end
		end

		// Auto close of a write waits out the store recovery time
		if (r.wrc_act) begin
			if (r.wrc == 2'h1) begin
				next_r.wrc_act          = 1'b0;
				next_r.open[r.wrc_bank] = 1'b0;
			end else begin
				next_r.wrc = r.wrc - 2'h1;
			end
		end

		if (r.sref) begin
			if (cke) begin
				next_r.sref   = 1'b0;
				next_r.stimer = 8'h00;
			end else if (r.stimer == `SDR_SREF_CYC - 8'h01) begin
				next_r.stimer = 8'h00;
				next_r.rcount = r.rcount + 16'h0001;
			end else begin
				next_r.stimer = r.stimer + 8'h01;
			end
		end

		if (cmd_mrs) begin
			next_r.bl      = link.addr[`SDR_MR_BL_HI:`SDR_MR_BL_LO];
			next_r.bt      = link.addr[`SDR_MR_BT];
			next_r.cl      = link.addr[`SDR_MR_CL_HI:`SDR_MR_CL_LO];
			next_r.wsingle = link.addr[`SDR_MR_WM];
		end

		if (cmd_act) begin
			next_r.open[bank] = 1'b1;
		end

		if (cmd_pre) begin
			if (link.addr[`SDR_AP_BIT]) begin
				next_r.open = 4'h0;
				next_r.bact = 1'b0;
			end else begin
				next_r.open[bank] = 1'b0;
				if (r.bbank == bank) begin
					next_r.bact = 1'b0;
				end
			end
		end

		// Refresh address comes from the internal counter only
		if (cmd_ref) begin
			next_r.rcount = r.rcount + 16'h0001;
		end

		if (cmd_sref) begin
			next_r.sref   = 1'b1;
			next_r.stimer = 8'h00;
			next_r.rcount = r.rcount + 16'h0001;
		end

		// New burst overrides any burst in flight
		if (cmd_rd || cmd_wr) begin
			next_r.bact   = 1'b1;
			next_r.bwr    = cmd_wr;
			next_r.bauto  = link.addr[`SDR_AP_BIT];
			next_r.bbank  = bank;
			next_r.bstart = link.addr[9:0];
			next_r.beat   = 10'h000;
			if (cmd_wr) begin
				next_r.mem[{bank, link.addr[3:0]}] = link.dq;
				next_r.beat = 10'h001;
				if (r.wsingle || (r.bl == `SDR_BL_1)) begin
					next_r.bact = 1'b0;
					if (link.addr[`SDR_AP_BIT]) begin
						next_r.wrc_act  = 1'b1;
						next_r.wrc      = `SDR_TWR_CYC;
						next_r.wrc_bank = bank;
					end
				end
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			r    <= '0;
			r.bl <= `SDR_BL_1;
			r.cl <= `SDR_CL_3;
		end else begin
			r <= next_r;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Only array data leaves the device; mode fields have no read path
	always_comb begin
		if (r.cl == `SDR_CL_2) begin
			link.mem_dq_oe = r.s1v;
			link.mem_dq_o  = r.s1d;
		end else begin
			link.mem_dq_oe = r.s2v;
			link.mem_dq_o  = r.s2d;
		end
	end

	assign bank_open       = r.open;
	assign refresh_count   = r.rcount;
	assign in_self_refresh = r.sref;

endmodule

// ---- rtl/sdr_pkg.sv ----
// Types shared by both ends of the DRAM link
package sdr_pkg;

	typedef enum logic [2:0] {
		SDR_OP_NOP  = 3'h0,
		SDR_OP_MRS  = 3'h1,
		SDR_OP_ACT  = 3'h2,
		SDR_OP_RD   = 3'h3,
		SDR_OP_WR   = 3'h4,
		SDR_OP_PRE  = 3'h5,
		SDR_OP_REF  = 3'h6,
		SDR_OP_SREF = 3'h7
	} sdr_op_e;

	typedef enum logic [1:0] {
		SDR_C_IDLE = 2'h0,
		SDR_C_CMD  = 2'h1,
		SDR_C_WAIT = 2'h3
	} sdr_cstate_e;

	typedef struct packed {
		logic [2:0]       bl;
		logic             bt;
		logic [2:0]       cl;
		logic             wsingle;
		logic [3:0]       open;
		logic [15:0]      rcount;
		logic             sref;
		logic [7:0]       stimer;
		logic             bact;
		logic             bwr;
		logic             bauto;
		logic [1:0]       bbank;
		logic [9:0]       bstart;
		logic [9:0]       beat;
		logic             wrc_act;
		logic [1:0]       wrc;
		logic [1:0]       wrc_bank;
		logic             s1v;
		logic [7:0]       s1d;
		logic             s2v;
		logic [7:0]       s2d;
		logic [63:0][7:0] mem;
	} sdr_dev_s;

	typedef struct packed {
		sdr_cstate_e state;
		sdr_op_e     op;
		logic        apf;
		logic [1:0]  bank;
		logic [12:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		logic        err;
		logic        sref;
		logic [3:0]  open;
		logic [2:0]  bl;
		logic        bt;
		logic [2:0]  cl;
		logic        wsingle;
		logic [7:0]  cnt;
		logic [7:0]  total;
		logic [7:0]  wlen;
		logic        cke;
		logic [2:0]  rcw_n;
		logic [12:0] a;
		logic        ba_lo;
		logic        ba_hi;
		logic [7:0]  dq_o;
		logic        dq_oe;
		logic [31:0] prdata;
	} sdr_ctl_s;

endpackage

// ---- tb/sdr_link_checker.sv ----
// Concurrent checks on the pins between the DRAM controller and the memory
`timescale 1ns/1ps
module sdr_link_checker (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Command pins and memory data enable
	input wire logic        clock_gate_in,
	input wire logic        row_strobe_n,
	input wire logic        column_strobe_n,
	input wire logic        write_enable_n,
	input wire logic [12:0] addr,
	input wire logic        array_pick_lo,
	input wire logic        array_pick_hi,
	input wire logic        mem_dq_oe,
	// Memory state
	input wire logic [3:0]  bank_open,
	input wire logic [15:0] refresh_count,
	input wire logic        in_self_refresh
);
	logic [2:0] s;
	logic       live, pre, aref, sref_in, rd, wr, wr1, acc, mrs;
	logic [7:0] m_q;
	logic [1:0] bk_q;

	assign s       = {row_strobe_n, column_strobe_n, write_enable_n};
	assign live    = clock_gate_in && !in_self_refresh;
	assign pre     = live && s == 3'b010;
	assign aref    = live && s == 3'b001;
	assign sref_in = !clock_gate_in && !in_self_refresh && s == 3'b001;
	assign rd      = live && s == 3'b101;
	assign wr      = live && s == 3'b100;
	assign mrs     = live && s == 3'b000;
	assign acc     = aref || rd || wr || (live && s == 3'b011);
	assign wr1     = wr && addr[10] && (m_q[2:0] == 3'h0 || m_q[7]);

	// ****************************************
	// Mode mirror
	// ****************************************
	// Mode cannot be read back, so it is copied off the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_q  <= 8'h30;
			bk_q <= 2'h0;
		end else begin
			if (mrs)
				m_q <= addr[7:0];
			if (pre || rd || wr)
				bk_q <= {array_pick_lo, array_pick_hi};
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_rd_close;
		bank_open[bk_q] ##[1:19] !bank_open[bk_q];
	endsequence
	sequence s_wr_close;
		bank_open[bk_q] [*2] ##1 !bank_open[bk_q];
	endsequence

	AST_PRE_BANK: assert property (pre && !addr[10] |=> !bank_open[bk_q])
		else $error("single bank precharge missed");
	AST_PRE_ALL: assert property (pre && addr[10] |=> bank_open == 4'h0)
		else $error("precharge all left a bank open");
	AST_AREF: assert property (aref |=> refresh_count == $past(refresh_count) + 16'h0001
		&& bank_open == 4'h0) else $error("auto refresh count or close wrong");
	AST_REF_CLOSED: assert property (aref || sref_in |-> bank_open == 4'h0)
		else $error("refresh with a bank open");
	AST_REF_GAP: assert property (aref |=> !acc)
		else $error("access too soon after auto refresh");
	AST_SREF_IN: assert property (sref_in |=> in_self_refresh
		&& refresh_count == $past(refresh_count) + 16'h0001) else $error("self refresh entry");
	AST_SREF_HOLD: assert property (in_self_refresh && !clock_gate_in |=> in_self_refresh
		&& $stable(bank_open) && !mem_dq_oe) else $error("input acted on in self refresh");
	AST_SREF_OUT: assert property (in_self_refresh && clock_gate_in |-> ##[1:2] !in_self_refresh)
		else $error("self refresh not left");
	AST_SREF_GAP: assert property ($rose(clock_gate_in) |=> !acc ##1 !acc)
		else $error("access too soon after self refresh exit");
	AST_DQ_LAT: assert property ($rose(mem_dq_oe) |-> (m_q[6:4] == 3'h2 && $past(rd, 2))
		|| (m_q[6:4] == 3'h3 && $past(rd, 3))) else $error("read data at wrong latency");
	AST_RD_AP: assert property (rd && addr[10] |=> s_rd_close)
		else $error("read auto close timing");
	AST_WR_AP: assert property (wr1 |=> s_wr_close)
		else $error("write auto close timing");
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench: controller and memory joined over the DRAM link
`timescale 1ns/1ps
`include "sdr_cfg.svh"
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin bad_count++; \
	$display("wrong value at %0t got %h expected %h", $time, g, x); end end
module tb_top;
	import sdr_pkg::*;
	typedef struct packed {
		logic [12:0] m;
		logic [3:0]  c;
		logic [31:0] x;
	} sdr_row_s;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, in_self_refresh;
	logic [7:0]  paddr, d;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  bank_open;
	logic [15:0] refresh_count, rc;
	logic [1:0]  pb;
	int          bad_count, n_checks, n;
	logic [12:0] bad_m [3] = '{13'h0010, 13'h0040, 13'h003F};
	// Mode, start column, columns of beats 0..7 one nibble each
	sdr_row_s    rows [8] = '{
		'{13'h0021, 4'h1, 32'h0000_0001}, '{13'h0032, 4'h1, 32'h0000_0321},
		'{13'h002A, 4'h1, 32'h0000_2301}, '{13'h0033, 4'h5, 32'h4321_0765},
		'{13'h002B, 4'h1, 32'h6745_2301}, '{13'h003B, 4'hA, 32'hDCFE_98BA},
		'{13'h0020, 4'h3, 32'h0000_0003}, '{13'h0037, 4'h3, 32'hA987_6543}};

	sdr_link_if sdr_link_if_inst (.pclk(pclk), .presetn(presetn));
	sdr_ctl sdr_ctl_inst (.link(sdr_link_if_inst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	sdr_mem_dev sdr_mem_dev_inst (.link(sdr_link_if_inst), .bank_open(bank_open),
		.refresh_count(refresh_count), .in_self_refresh(in_self_refresh));
	sdr_link_checker sdr_link_checker_inst (.pclk(pclk), .presetn(presetn),
		.clock_gate_in(sdr_link_if_inst.clock_gate_in),
		.row_strobe_n(sdr_link_if_inst.row_strobe_n),
		.column_strobe_n(sdr_link_if_inst.column_strobe_n),
		.write_enable_n(sdr_link_if_inst.write_enable_n), .addr(sdr_link_if_inst.addr),
		.array_pick_lo(sdr_link_if_inst.array_pick_lo),
		.array_pick_hi(sdr_link_if_inst.array_pick_hi),
		.mem_dq_oe(sdr_link_if_inst.mem_dq_oe), .bank_open(bank_open),
		.refresh_count(refresh_count), .in_self_refresh(in_self_refresh));

	// Bank pins of the last single-bank precharge
	always @(posedge pclk) begin
		if (presetn && !sdr_link_if_inst.addr[10] && !sdr_link_if_inst.row_strobe_n
			&& sdr_link_if_inst.column_strobe_n && !sdr_link_if_inst.write_enable_n)
			pb = {sdr_link_if_inst.array_pick_lo, sdr_link_if_inst.array_pick_hi};
	end

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Flags: bit 1 close all, bit 0 auto close; last status stays in r
	task automatic cmd(input sdr_op_e op, input logic [1:0] b, input logic [1:0] f);
		apb(1'b1, `SDR_REG_CMD, {25'h0, b, f, op});
		// Only the watchdog ends a controller that never goes idle
		do
			apb(1'b0, `SDR_REG_STATUS, 32'h0);
		while (r[0] !== 1'b0);
	endtask

	task automatic setm(input logic [12:0] m);
		apb(1'b1, `SDR_REG_ADDR, {19'h0, m});
		cmd(SDR_OP_MRS, 2'h0, 2'h0);
	endtask

	task automatic xfer(input sdr_op_e op, input logic [3:0] c, input logic [7:0] v,
		input logic [1:0] b, input logic [1:0] f);
		apb(1'b1, `SDR_REG_ADDR, {28'h0, c});
		apb(1'b1, `SDR_REG_WDATA, {24'h0, v});
		cmd(op, b, f);
	endtask

	task automatic rdc(input logic [3:0] c, input logic [7:0] x);
		xfer(SDR_OP_RD, c, 8'h00, 2'h0, 2'h0);
		`CHK(r[15:8], x)
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Whole run is under two thousand cycles
	initial begin
		repeat (50000) @(posedge pclk);
		bad_count++;
		give_verdict();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		bad_count = 0;
		n_checks = 0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		cmd(SDR_OP_ACT, 2'h0, 2'h0);
		for (int i = 0; i < 8; i++) begin
			d = {i[3:0] + 4'h1, 4'h0};
			setm(rows[i].m);
			xfer(SDR_OP_WR, rows[i].c, d, 2'h0, 2'h0);
			xfer(SDR_OP_RD, rows[i].c, 8'h00, 2'h0, 2'h0);
			`CHK(r[15:8], d)
			n = (rows[i].m[2:0] == `SDR_BL_FULL) ? 8 : (1 << rows[i].m[1:0]);
			setm(13'h0030);
			for (int b = 0; b < n; b++)
				rdc(rows[i].x[4*b +: 4], d + b[7:0]);
		end
		xfer(SDR_OP_WR, 4'h1, 8'h55, 2'h0, 2'h0);
		setm(13'h00B2);
		xfer(SDR_OP_WR, 4'h0, 8'hC0, 2'h0, 2'h0);
		setm(13'h0030);
		rdc(4'h0, 8'hC0);
		rdc(4'h1, 8'h55);
		foreach (bad_m[i]) begin
			setm(bad_m[i]);
			`CHK(r[1], 1'b1)
			apb(1'b1, `SDR_REG_STATUS, 32'h0000_0002);
		end
		rdc(4'h0, 8'hC0);
		apb(1'b0, 8'h10, 32'h0);
		`CHK({e, r}, {1'b1, 32'h0})
		cmd(SDR_OP_PRE, 2'h0, 2'h2);
		`CHK(bank_open, 4'h0)
		for (int b = 0; b < 4; b++) begin
			cmd(SDR_OP_ACT, b[1:0], 2'h0);
			`CHK(bank_open, 4'h1 << b)
			cmd(SDR_OP_PRE, b[1:0], 2'h0);
			`CHK({pb, bank_open}, {b[1:0], 4'h0})
		end
		cmd(SDR_OP_ACT, 2'h2, 2'h0);
		xfer(SDR_OP_WR, 4'h2, 8'h3C, 2'h2, 2'h1);
		`CHK(bank_open, 4'h0)
		cmd(SDR_OP_ACT, 2'h3, 2'h0);
		xfer(SDR_OP_RD, 4'h2, 8'h00, 2'h3, 2'h1);
		`CHK(bank_open, 4'h0)
		rc = refresh_count;
		cmd(SDR_OP_REF, 2'h0, 2'h0);
		`CHK(refresh_count, rc + 16'h0001)
		cmd(SDR_OP_ACT, 2'h1, 2'h0);
		cmd(SDR_OP_REF, 2'h0, 2'h0);
		`CHK({r[1], refresh_count}, {1'b1, rc + 16'h0001})
		cmd(SDR_OP_PRE, 2'h0, 2'h2);
		apb(1'b1, `SDR_REG_STATUS, 32'h0000_0002);
		cmd(SDR_OP_SREF, 2'h0, 2'h0);
		`CHK({in_self_refresh, sdr_link_if_inst.clock_gate_in}, 2'b10)
		rc = refresh_count;
		repeat (40) @(posedge pclk);
		cmd(SDR_OP_ACT, 2'h1, 2'h0);
		`CHK({r[1], bank_open}, {1'b1, 4'h0})
		`CHK(refresh_count - rc >= 16'h0002, 1'b1)
		cmd(SDR_OP_SREF, 2'h0, 2'h0);
		`CHK({in_self_refresh, sdr_link_if_inst.clock_gate_in}, 2'b01)
		cmd(SDR_OP_ACT, 2'h1, 2'h0);
		`CHK(bank_open, 4'h2)
		// Mid-run reset: both ends must come back in the same mode
		presetn <= 1'b0;
		@(posedge pclk);
		`CHK({bank_open, refresh_count, in_self_refresh, sdr_link_if_inst.clock_gate_in}, 22'h00_0001)
		presetn <= 1'b1;
		cmd(SDR_OP_ACT, 2'h0, 2'h0);
		xfer(SDR_OP_WR, 4'h0, 8'hA5, 2'h0, 2'h0);
		rdc(4'h0, 8'hA5);
		give_verdict();
	end
endmodule
